/* hw/lkt_regs.svh */
// offsets, field positions, reset values for the legacy trap register bank
`ifndef LKT_REGS_SVH
`define LKT_REGS_SVH
`define LKT_OFF_CMD 3'h0
`define LKT_OFF_STS 3'h2
`define LKT_OFF_IEN 3'h4
`define LKT_OFF_LEG 3'h6
`define LKT_LEG_RESET 16'h2000
`define LKT_CMD_RESET 16'h0000
`define LKT_STS_RESET 16'h0020
`define LKT_IEN_RESET 16'h0000
`define LKT_CMD_MASK 16'h00ff
`define LKT_IEN_MASK 16'h000f
`define LKT_STS_W1C_MASK 16'h001f
`define LKT_LEG_W1C_MASK 16'h8f00
`define LKT_LEG_RW_MASK 16'h20bf
`define LKT_BIT_DONE 15
`define LKT_BIT_PIRQ 13
`define LKT_BIT_IRQS 12
`define LKT_BIT_T64W 11
`define LKT_BIT_T64R 10
`define LKT_BIT_T60W 9
`define LKT_BIT_T60R 8
`define LKT_BIT_SMIPT 7
`define LKT_BIT_PSS 6
`define LKT_BIT_PTEN 5
`define LKT_BIT_SMIIRQ 4
`define LKT_BIT_HALT 5
`define LKT_KBC_FF 8'hff
`define LKT_KBC_WOUT 8'hd1
`endif

/* hw/lkt_pkg.sv */
// types for the legacy trap register bank
package lkt_pkg;
	typedef enum logic [1:0] {
		LKT_PT_IDLE = 2'b00,
		LKT_PT_CMD = 2'b01,
		LKT_PT_DATA = 2'b10,
		LKT_PT_FIN = 2'b11
	} lkt_pt_state_t;
endpackage

/* hw/lkt_pt_seq.sv */
// gate pass-through sequence tracker
`timescale 1ns/1ns
`default_nettype none
`include "lkt_regs.svh"
module lkt_pt_seq (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_enable,
	input wire logic i_skip_last,
	input wire logic i_wr60,
	input wire logic i_wr64,
	input wire logic [7:0] i_data,
	output logic o_busy,
	output logic o_done
);
	lkt_pkg::lkt_pt_state_t state_reg, state_next;
	logic done_next;
	wire is_wout = i_wr64 && (i_data == `LKT_KBC_WOUT);
	wire is_ff = i_wr64 && (i_data == `LKT_KBC_FF);
	always_comb begin
		state_next = state_reg;
		done_next = 1'b0;
		case (state_reg)
		lkt_pkg::LKT_PT_IDLE: begin
			if (i_enable && is_wout)
				state_next = lkt_pkg::LKT_PT_CMD;
		end
		lkt_pkg::LKT_PT_CMD: begin
			if (i_wr60) begin
				if (i_skip_last) begin
					state_next = lkt_pkg::LKT_PT_IDLE;
					done_next = 1'b1;
				end else begin
					state_next = lkt_pkg::LKT_PT_FIN;
				end
			end else if (i_wr64 && !is_wout) begin
				state_next = lkt_pkg::LKT_PT_IDLE;
			end
		end
		lkt_pkg::LKT_PT_FIN: begin
			if (is_ff) begin
				state_next = lkt_pkg::LKT_PT_IDLE;
				done_next = 1'b1;
			end else if (i_wr60 || i_wr64) begin
				state_next = lkt_pkg::LKT_PT_IDLE;
			end
		end
		default: state_next = lkt_pkg::LKT_PT_IDLE;
		endcase
		if (!i_enable)
			state_next = lkt_pkg::LKT_PT_IDLE;
	end
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_reg <= lkt_pkg::LKT_PT_IDLE;
			o_done <= 1'b0;
			o_busy <= 1'b0;
		end else begin
			state_reg <= state_next;
			o_done <= done_next;
			o_busy <= (state_next != lkt_pkg::LKT_PT_IDLE);
		end
	end
endmodule
`default_nettype wire

/* hw/lkt_bank.sv */
// legacy keyboard trap and host controller command/status register bank
`timescale 1ns/1ns
`default_nettype none
`include "lkt_regs.svh"
module lkt_bank (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic [2:0] i_addr,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [15:0] i_wdata,
	input wire logic i_io_rd60,
	input wire logic i_io_wr60,
	input wire logic i_io_rd64,
	input wire logic i_io_wr64,
	input wire logic [7:0] i_io_wdata,
	input wire logic i_trap_ignores_en,
	input wire logic i_skip_last_cmd,
	input wire logic i_ctrl_irq,
	input wire logic i_halted,
	input wire logic [4:0] i_status_events,
	output logic [15:0] o_rdata,
	output logic o_smi,
	output logic o_pci_irq,
	output logic [7:0] o_command,
	output logic [3:0] o_int_enable
);
	logic [15:0] leg_reg, cmd_reg, sts_reg, ien_reg;
	logic [15:0] leg_next, cmd_next, sts_next, ien_next;
	logic irq_s1_reg, irq_s2_reg;
	logic pt_busy, pt_done;
	logic [3:0] io_s1_reg, io_s2_reg, io_s3_reg;
	// port data comes with the strobes, so it is synced the same way
	logic [7:0] iod_s1_reg, iod_s2_reg;

	// decoding shared by every register write
	function automatic logic hit(input logic [2:0] a, input logic [2:0] o);
		hit = (a == o);
	endfunction

	// port strobes arrive from another domain: two stages, then edge detect
	wire [3:0] io_raw = {i_io_wr64, i_io_rd64, i_io_wr60, i_io_rd60};
	wire [3:0] io_pulse = io_s2_reg & ~io_s3_reg;
	wire [15:0] wd = i_wdata;
	wire wr_leg = i_wr && hit(i_addr, `LKT_OFF_LEG);
	wire wr_cmd = i_wr && hit(i_addr, `LKT_OFF_CMD);
	wire wr_sts = i_wr && hit(i_addr, `LKT_OFF_STS);
	wire wr_ien = i_wr && hit(i_addr, `LKT_OFF_IEN);
	wire [3:0] trap_en = leg_reg[3:0];
	wire [3:0] trap_set;
	wire [3:0] smi_src;
	wire [15:0] leg_rw = wr_leg ? (wd & `LKT_LEG_RW_MASK)
		: (leg_reg & `LKT_LEG_RW_MASK);
	wire [15:0] leg_w1c_clr = wr_leg ? (wd & `LKT_LEG_W1C_MASK) : 16'h0000;
	wire [15:0] leg_sticky = leg_reg & `LKT_LEG_W1C_MASK & ~leg_w1c_clr;
	wire [15:0] leg_set = {pt_done, 3'b000, trap_set, 8'h00};
	wire [15:0] sts_clr = wr_sts ? (wd & `LKT_STS_W1C_MASK) : 16'h0000;

	// one generate lane per trapped access kind
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_trap
			// the option lets a flag set even with its enable off
			assign trap_set[g] = io_pulse[g]
				&& (i_trap_ignores_en || trap_en[g]);
			assign smi_src[g] = leg_reg[8 + g]
				&& trap_en[g];
		end
	endgenerate

	// set is ored after the clear so an event in the clear cycle survives
	assign leg_next = (leg_sticky | (leg_set & `LKT_LEG_W1C_MASK))
		| leg_rw;
	assign cmd_next = wr_cmd ? (wd & `LKT_CMD_MASK) : cmd_reg;
	assign sts_next = ((sts_reg & `LKT_STS_W1C_MASK & ~sts_clr)
		| {11'h000, i_status_events})
		| (i_halted ? 16'h0020 : 16'h0000);
	assign ien_next = wr_ien ? (wd & `LKT_IEN_MASK) : ien_reg;

	wire smi_any = (|smi_src)
		|| (leg_reg[`LKT_BIT_DONE] && leg_reg[`LKT_BIT_SMIPT])
		|| (irq_s2_reg && leg_reg[`LKT_BIT_SMIIRQ]);

	// live view of the status bits folded into the read value
	wire [15:0] leg_view = (leg_reg & 16'hafbf)
		| (irq_s2_reg ? 16'h1000 : 16'h0000)
		| (pt_busy ? 16'h0040 : 16'h0000);
	wire [15:0] rd_mux = hit(i_addr, `LKT_OFF_CMD) ? cmd_reg
		: hit(i_addr, `LKT_OFF_STS) ? sts_reg
		: hit(i_addr, `LKT_OFF_IEN) ? ien_reg
		: hit(i_addr, `LKT_OFF_LEG) ? leg_view : 16'h0000;

	lkt_pt_seq u_pt (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_enable(leg_reg[`LKT_BIT_PTEN]),
		.i_skip_last(i_skip_last_cmd),
		.i_wr60(io_pulse[1]),
		.i_wr64(io_pulse[3]),
		.i_data(iod_s2_reg),
		.o_busy(pt_busy),
		.o_done(pt_done)
	);

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			io_s1_reg <= 4'h0;
			io_s2_reg <= 4'h0;
			io_s3_reg <= 4'h0;
			irq_s1_reg <= 1'b0;
			irq_s2_reg <= 1'b0;
			iod_s1_reg <= 8'h00;
			iod_s2_reg <= 8'h00;
		end else begin
			io_s1_reg <= io_raw;
			io_s2_reg <= io_s1_reg;
			io_s3_reg <= io_s2_reg;
			irq_s1_reg <= i_ctrl_irq;
			irq_s2_reg <= irq_s1_reg;
			iod_s1_reg <= i_io_wdata;
			iod_s2_reg <= iod_s1_reg;
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			leg_reg <= `LKT_LEG_RESET;
			cmd_reg <= `LKT_CMD_RESET;
			sts_reg <= `LKT_STS_RESET;
			ien_reg <= `LKT_IEN_RESET;
		end else begin
			leg_reg <= leg_next;
			cmd_reg <= cmd_next;
			sts_reg <= sts_next;
			ien_reg <= ien_next;
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_rdata <= 16'h0000;
			o_smi <= 1'b0;
			o_pci_irq <= 1'b0;
			o_command <= 8'h00;
			o_int_enable <= 4'h0;
		end else begin
			o_rdata <= i_rd ? rd_mux : 16'h0000;
			o_smi <= smi_any;
			o_pci_irq <= irq_s2_reg && leg_reg[`LKT_BIT_PIRQ];
			o_command <= cmd_next[7:0];
			o_int_enable <= ien_next[3:0];
		end
	end
endmodule
`default_nettype wire

/* tb/lkt_bank_checker.sv */
// port assertions for the legacy trap bank
`timescale 1ns/1ns
`default_nettype none
module lkt_bank_checker (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic [2:0] i_addr,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [15:0] i_wdata,
	input wire logic i_ctrl_irq,
	input wire logic [15:0] o_rdata,
	input wire logic o_pci_irq,
	input wire logic [7:0] o_command,
	input wire logic [3:0] o_int_enable
);
	default clocking @(posedge i_clk);
	endclocking
	default disable iff (!i_nrst);
	wire rl = i_rd && i_addr == 3'h6;
	wire wl = i_wr && i_addr == 3'h6;
	chk_bit14_zero: assert property (rl |=> !o_rdata[14])
		else $error("bit 14 set");
	chk_cmd_upper: assert property (i_rd && i_addr == 3'h0 |=>
		o_rdata[15:8] == 8'h00) else $error("cmd upper set");
	chk_sts_upper: assert property (i_rd && i_addr == 3'h2 |=>
		o_rdata[15:6] == 10'h000) else $error("sts upper set");
	chk_cmd_copy: assert property (i_wr && i_addr == 3'h0 |=>
		o_command == $past(i_wdata[7:0])) else $error("cmd copy");
	chk_ien_copy: assert property (i_wr && i_addr == 3'h4 |=>
		o_int_enable == $past(i_wdata[3:0])) else $error("ien copy");
	chk_irq_live: assert property (i_ctrl_irq [*5] ##0 rl |=>
		o_rdata[12]) else $error("irq bit low");
	chk_pci_gate: assert property (wl && !i_wdata[13] |=>
		##[0:2] !o_pci_irq) else $error("pci not gated");
	chk_leg_rw: assert property (wl ##2 rl |=>
		{o_rdata[7], o_rdata[5:0]} ==
		{$past(i_wdata[7], 3), $past(i_wdata[5:0], 3)})
		else $error("legacy rw");
endmodule
bind lkt_bank lkt_bank_checker chk_u (.i_clk, .i_nrst, .i_addr, .i_wr,
	.i_rd, .i_wdata, .i_ctrl_irq, .o_rdata, .o_pci_irq, .o_command,
	.o_int_enable);
`default_nettype wire

/* tb/lkt_host_model.sv */
// keyboard port access model for host software
`timescale 1ns/1ns
`default_nettype none
module lkt_host_model (
	input wire logic i_clk,
	output logic [3:0] o_io,
	output logic [7:0] o_io_wdata
);
	initial begin
		o_io = 4'h0;
		o_io_wdata = 8'h00;
	end
	// order rd60 wr60 rd64 wr64; data flipped after so stale never matches
	task automatic access(input int k, input logic [7:0] d);
		o_io_wdata = d;
		o_io[k] = 1'b1;
		repeat (4) @(posedge i_clk);
		#1 o_io[k] = 1'b0;
		o_io_wdata = ~d;
		repeat (4) @(posedge i_clk);
		#1;
	endtask
endmodule
`default_nettype wire

/* tb/lkt_bank_tb.sv */
// self-checking bench for the legacy trap bank
`timescale 1ns/1ns
`default_nettype none
module lkt_bank_tb;
	logic i_clk = 1'b0;
	logic i_nrst = 1'b0;
	logic [2:0] i_addr = 3'h0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [15:0] i_wdata = 16'h0000;
	logic i_ctrl_irq = 1'b0;
	logic i_halted = 1'b1;
	logic [4:0] i_status_events = 5'h00;
	logic ign_en = 1'b0;
	logic skip_last = 1'b0;
	logic [3:0] io;
	logic [7:0] iod;
	logic [15:0] o_rdata;
	logic o_smi;
	logic o_pci_irq;
	logic [7:0] o_command;
	logic [3:0] o_int_enable;
	int fail_count = 0;
	int n_checks = 0;
	always #5 i_clk = ~i_clk;
	lkt_host_model hm_u (.i_clk(i_clk), .o_io(io), .o_io_wdata(iod));
	lkt_bank dut_u (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr),
		.i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata), .i_io_rd60(io[0]),
		.i_io_wr60(io[1]), .i_io_rd64(io[2]), .i_io_wr64(io[3]),
		.i_io_wdata(iod), .i_trap_ignores_en(ign_en),
		.i_skip_last_cmd(skip_last), .i_ctrl_irq(i_ctrl_irq),
		.i_halted(i_halted), .i_status_events(i_status_events),
		.o_rdata(o_rdata), .o_smi(o_smi), .o_pci_irq(o_pci_irq),
		.o_command(o_command), .o_int_enable(o_int_enable));
	task automatic print_verdict();
		if (fail_count == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		i_addr = a;
		i_wdata = d;
		i_wr = 1'b1;
		@(posedge i_clk);
		#1 i_wr = 1'b0;
		@(posedge i_clk);
		#1;
	endtask
	task automatic rd(input logic [2:0] a, input logic [15:0] e);
		i_addr = a;
		i_rd = 1'b1;
		@(posedge i_clk);
		#1 i_rd = 1'b0;
		cmp(o_rdata, e);
		@(posedge i_clk);
		#1;
	endtask
	task automatic t_reset();
		rd(3'h0, 16'h0000);
		rd(3'h2, 16'h0020);
		rd(3'h4, 16'h0000);
		rd(3'h6, 16'h2000);
		rd(3'h1, 16'h0000);
	endtask
	task automatic t_rw();
		wr(3'h0, 16'hffff);
		wr(3'h4, 16'hffff);
		wr(3'h6, 16'hffff);
		wr(3'h7, 16'hffff);
		rd(3'h0, 16'h00ff);
		rd(3'h4, 16'h000f);
		rd(3'h6, 16'h20bf);
		rd(3'h7, 16'h0000);
		cmp({o_command, 4'h0, o_int_enable}, 16'hff0f);
	endtask
	task automatic t_trap(input int k);
		logic [15:0] en;
		logic [15:0] fl;
		en = 16'h2000 | (16'h0001 << k);
		fl = 16'h0100 << k;
		wr(3'h6, 16'h2000);
		hm_u.access(k, 8'h00);
		rd(3'h6, 16'h2000);
		wr(3'h6, en);
		hm_u.access(k, 8'h00);
		rd(3'h6, en | fl);
		cmp(16'(o_smi), 16'h0001);
		wr(3'h6, en | fl);
		rd(3'h6, en);
		cmp(16'(o_smi), 16'h0000);
	endtask
	task automatic t_pass();
		wr(3'h6, 16'h20a0);
		hm_u.access(3, 8'hd1);
		rd(3'h6, 16'h20e0);
		hm_u.access(1, 8'hdf);
		hm_u.access(3, 8'hff);
		rd(3'h6, 16'ha0a0);
		cmp(16'(o_smi), 16'h0001);
		wr(3'h6, 16'ha0a0);
		rd(3'h6, 16'h20a0);
		cmp(16'(o_smi), 16'h0000);
	endtask
	task automatic t_irq();
		wr(3'h6, 16'h2000);
		i_ctrl_irq = 1'b1;
		repeat (6) @(posedge i_clk);
		#1;
		rd(3'h6, 16'h3000);
		cmp(16'(o_pci_irq), 16'h0001);
		wr(3'h6, 16'h0010);
		rd(3'h6, 16'h1010);
		cmp({14'h0000, o_pci_irq, o_smi}, 16'h0001);
		i_ctrl_irq = 1'b0;
		wr(3'h6, 16'h2000);
		rd(3'h6, 16'h2000);
		cmp(16'(o_smi), 16'h0000);
	endtask
	task automatic t_status();
		i_status_events = 5'h1f;
		@(posedge i_clk);
		#1 i_status_events = 5'h00;
		rd(3'h2, 16'h003f);
		i_halted = 1'b0;
		wr(3'h2, 16'hffff);
		rd(3'h2, 16'h0000);
		i_addr = 3'h2;
		i_wdata = 16'h0001;
		i_wr = 1'b1;
		i_status_events = 5'h01;
		@(posedge i_clk);
		#1 i_wr = 1'b0;
		i_status_events = 5'h00;
		rd(3'h2, 16'h0001);
	endtask
	task automatic t_opts();
		ign_en = 1'b1;
		wr(3'h6, 16'h2000);
		hm_u.access(2, 8'h00);
		rd(3'h6, 16'h2400);
		cmp(16'(o_smi), 16'h0000);
		wr(3'h6, 16'h2400);
		ign_en = 1'b0;
		skip_last = 1'b1;
		wr(3'h6, 16'h2020);
		hm_u.access(3, 8'hd1);
		hm_u.access(1, 8'hdf);
		rd(3'h6, 16'ha020);
		cmp(16'(o_smi), 16'h0000);
		wr(3'h6, 16'h8000);
		rd(3'h6, 16'h0000);
		skip_last = 1'b0;
	endtask
	task automatic t_midrst();
		wr(3'h0, 16'h00a5);
		i_halted = 1'b1;
		i_nrst = 1'b0;
		@(posedge i_clk);
		#1;
		cmp({o_command, 4'h0, o_int_enable}, 16'h0000);
		cmp({14'h0000, o_pci_irq, o_smi}, 16'h0000);
		@(posedge i_clk);
		#1 i_nrst = 1'b1;
		@(posedge i_clk);
		#1;
		t_reset();
	endtask
	initial begin
		repeat (3) @(posedge i_clk);
		#1 i_nrst = 1'b1;
		@(posedge i_clk);
		#1;
		t_reset();
		t_rw();
		for (int k = 0; k < 4; k++) begin
			t_trap(k);
		end
		t_pass();
		t_irq();
		t_status();
		t_opts();
		t_midrst();
		print_verdict();
	end
endmodule
`default_nettype wire
